/* rtl/gds_config_reg.sv */
/*
  global configuration word storage.
  assumes write strobe, address and data arrive together for one cycle.
*/
`timescale 1ns/10ps
module gds_config_reg
  import gds_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // write port
  input wire logic we_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  // stored value
  output logic [7:0] cfg_o
);

  logic [7:0] cfg_q, cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (we_i && gds_addr_hit(addr_i, ADDR_GLOBAL_CONFIG_WORD)) begin
      cfg_d = wdata_i & CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= CFG_RESET_VAL;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_o = cfg_q;

endmodule : gds_config_reg

/* rtl/gds_pkg.sv */
/*
  constants shared by the gate driver status register bank.
  assumes a 20 MHz core clock and a host that keeps sck within a sixth of it.
*/
package gds_pkg;

  // ----------------------------------------------------------------
  // register addresses (7-bit, write flag in the address byte msb)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_GLOBAL_CONFIG_WORD = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_FAULT_FLAGS = 7'h01;
  localparam logic [6:0] ADDR_INPUT_PIN_MIRROR = 7'h04;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 40;
  localparam int ADDR_MSB = 39;
  localparam int ADDR_LSB = 32;
  localparam int WRITE_FLAG_BIT = 7;
  localparam logic [5:0] FRAME_BITS_COUNT = 6'h28;

  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_DISABLE_BIT = 0;
  localparam int CFG_SINGLELINE_BIT = 1;
  localparam int CFG_FAULTDIRECT_BIT = 2;
  localparam int CFG_AMP_LSB = 4;
  localparam int CFG_AMP_OFF_BIT = 6;
  localparam int CFG_TEST_MODE_BIT = 7;
  localparam logic [7:0] CFG_RESET_VAL = 8'h02;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hf7;

  // ----------------------------------------------------------------
  // fault flag fields
  // ----------------------------------------------------------------
  localparam int FLG_RESET_BIT = 0;
  localparam int FLG_PREWARN_BIT = 1;
  localparam int FLG_OVERTEMP_BIT = 2;
  localparam int FLG_PUMP_UV_BIT = 3;
  localparam int FLG_PHASE_BASE = 4;
  localparam int FLG_PHASE_STRIDE = 4;
  localparam int FLG_COUNTER_OFS = 0;
  localparam int FLG_GROUND_OFS = 1;
  localparam int FLG_SUPPLY_OFS = 2;
  localparam logic [14:0] FLG_RESET_VAL = 15'h0001;
  localparam logic [14:0] FLG_USED_MASK = 15'h777f;
  localparam logic [14:0] FLG_KEEP_ON_CYCLE = 15'h0003;
  localparam logic [14:0] FLG_STATUS_PIN_MASK = 15'h777c;

  // ----------------------------------------------------------------
  // input mirror fields
  // ----------------------------------------------------------------
  localparam int MIR_DRV_EN_BIT = 6;
  localparam int MIR_PREWARN_BIT = 7;

  function automatic logic gds_addr_hit(input logic [6:0] addr, input logic [6:0] target);
    gds_addr_hit = (addr == target);
  endfunction : gds_addr_hit

endpackage : gds_pkg

/* rtl/gds_reg_if.sv */
/*
  register access carrier between the serial engine and the register bank.
  assumes one clock domain; write strobe is a one-cycle pulse.
*/
`timescale 1ns/10ps
interface gds_reg_if;
  logic we;
  logic [6:0] addr;
  logic [31:0] wdata;
  logic [6:0] rd_addr;
  logic [31:0] rdata;
  logic [7:0] status;

  modport spi (output we, output addr, output wdata, output rd_addr,
               input rdata, input status);
  modport bank (input we, input addr, input wdata, input rd_addr,
                output rdata, output status);
endinterface : gds_reg_if

/* rtl/gds_spi_slave.sv */
/*
  serial engine: 40-bit frames, mode 3, msb first.
  assumes sck, csn and sdi are synchronous to clk_i and sck is at most clk/6.
*/
`timescale 1ns/10ps
module gds_spi_slave
  import gds_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial pins
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // register side
  gds_reg_if.spi bus
);

  typedef enum logic {SPI_IDLE, SPI_SHIFT} gds_spi_state_t;

  gds_spi_state_t state_q, state_d;
  logic sck_q, sck_d, csn_q, csn_d, sdo_q, sdo_d, we_q, we_d;
  logic [39:0] shift_q, shift_d;
  logic [5:0] cnt_q, cnt_d;
  logic [6:0] rd_addr_q, rd_addr_d, addr_q, addr_d;
  logic [31:0] wdata_q, wdata_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sck_d = sck_i;
    csn_d = csn_i;
    sdo_d = sdo_q;
    we_d = 1'b0;
    shift_d = shift_q;
    cnt_d = cnt_q;
    rd_addr_d = rd_addr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    case (state_q)
      SPI_IDLE: begin
        if (csn_q && !csn_i) begin
          // answer carries the register named in the previous frame
          shift_d = {bus.status, bus.rdata};
          sdo_d = bus.status[7];
          cnt_d = 6'h00;
          state_d = SPI_SHIFT;
        end
      end
      SPI_SHIFT: begin
        if (csn_i) begin
          // short or long frames are dropped whole
          if (cnt_q == FRAME_BITS_COUNT) begin
            rd_addr_d = shift_q[ADDR_LSB+6:ADDR_LSB];
            addr_d = shift_q[ADDR_LSB+6:ADDR_LSB];
            wdata_d = shift_q[31:0];
            we_d = shift_q[ADDR_LSB+WRITE_FLAG_BIT];
          end
          state_d = SPI_IDLE;
        end else if (sck_i && !sck_q) begin
          shift_d = {shift_q[38:0], sdi_i};
          if (cnt_q != 6'h3f) begin
            cnt_d = cnt_q + 6'h01;
          end
        end else if (!sck_i && sck_q) begin
          sdo_d = shift_q[ADDR_MSB];
        end
      end
      default: state_d = SPI_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= SPI_IDLE;
      sck_q <= 1'b1;
      csn_q <= 1'b1;
      sdo_q <= 1'b0;
      we_q <= 1'b0;
      shift_q <= 40'h00_0000_0000;
      cnt_q <= 6'h00;
      rd_addr_q <= 7'h00;
      addr_q <= 7'h00;
      wdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      sck_q <= sck_d;
      csn_q <= csn_d;
      sdo_q <= sdo_d;
      we_q <= we_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      rd_addr_q <= rd_addr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = (state_q == SPI_SHIFT);
  assign bus.we = we_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.rd_addr = rd_addr_q;

endmodule : gds_spi_slave

/* rtl/gds_status_regs.sv */
/*
  gate driver configuration and status register bank with its serial port.
  assumes protection detectors deliver levels or one-cycle pulses in the clk_i
  domain; gate inputs and the enable pin are already synchronous.
*/
`timescale 1ns/10ps

//
// Contract
// - amplifier-off bit 0 keeps sense amplifiers on, 1 powers them down.
// - test bit 7 routes selected analog probe onto enable pin; host keeps 0.
// - writing status register clears flags written with one, keeps others.
// - enable pin low-high cycle clears all flags except reset and prewarning.
// - clearing short flag alone never re-enables; gate inputs must go off first.
// - after reset, reset flag reads one and every register holds its reset value.
// - reset flag clear is ignored while enable pin is low.
// - prewarning flag latches on prewarning temperature, no protective action.
// - overtemperature flag latches on shutdown; clears only once temperature falls.
// - pump undervoltage disables driver and latches flag bit 3.
// - bits 4, 8, 12 latch when phase short counter fires.
// - bits 5, 9, 13 latch on ground short; phase off until cleared.
// - bits 6, 10, 14 latch on supply short; phase off until cleared.
// - status pin active while any overtemp, undervoltage or short flag set.
// - mirror register shows six gate inputs and enable pin at bit 6.
// - address byte msb clear reads, set writes.
module gds_status_regs
  import gds_pkg::*;
#(
  parameter int PHASES = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial host port
  input wire logic spi_sck_i,
  input wire logic spi_csn_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // gate control inputs
  input wire logic phase_a_low_input_i,
  input wire logic phase_a_high_input_i,
  input wire logic phase_b_low_input_i,
  input wire logic phase_b_high_input_i,
  input wire logic phase_c_low_input_i,
  input wire logic phase_c_high_input_i,
  input wire logic drv_en_i,
  // protection detectors
  input wire logic temp_prewarn_i,
  input wire logic overtemp_i,
  input wire logic pump_undervoltage_i,
  input wire logic [PHASES-1:0] short_counter_fire_i,
  input wire logic [PHASES-1:0] ground_short_i,
  input wire logic [PHASES-1:0] supply_short_i,
  // analog probe selection
  input wire logic [1:0] probe_func_i,
  // driver and analog controls
  output logic driver_enable_o,
  output logic [PHASES-1:0] phase_enable_o,
  output logic sense_amp_enable_o,
  output logic [1:0] amp_gain_o,
  output logic single_line_mode_o,
  output logic fault_direct_o,
  output logic probe_route_o,
  output logic [1:0] probe_func_o,
  // status pin
  output logic status_o
);

  // ----------------------------------------------------------------
  // serial engine and config word
  // ----------------------------------------------------------------
  gds_reg_if regs ();

  gds_spi_slave u_spi (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sck_i(spi_sck_i),
    .csn_i(spi_csn_i),
    .sdi_i(spi_sdi_i),
    .sdo_o(spi_sdo_o),
    .sdo_oe_o(spi_sdo_oe_o),
    .bus(regs.spi)
  );

  logic [7:0] cfg;

  gds_config_reg u_cfg (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(regs.we),
    .addr_i(regs.addr),
    .wdata_i(regs.wdata[7:0]),
    .cfg_o(cfg)
  );

  // ----------------------------------------------------------------
  // live pin vectors
  // ----------------------------------------------------------------
  logic [5:0] gate_in;
  logic [15:0] mirror;

  assign gate_in = {phase_c_high_input_i, phase_c_low_input_i,
                    phase_b_high_input_i, phase_b_low_input_i,
                    phase_a_high_input_i, phase_a_low_input_i};

  // mirror is live, not sampled, so a read returns the level at frame start
  always_comb begin
    mirror = 16'h0000;
    mirror[5:0] = gate_in;
    mirror[MIR_DRV_EN_BIT] = drv_en_i;
    mirror[MIR_PREWARN_BIT] = temp_prewarn_i;
  end

  // ----------------------------------------------------------------
  // enable pin cycle detect
  // ----------------------------------------------------------------
  logic drv_en_q, drv_en_d;
  logic drv_en_rise;

  always_comb begin
    drv_en_d = drv_en_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // taken as high so a pin already high gives no false edge after reset
      drv_en_q <= 1'b1;
    end else begin
      drv_en_q <= drv_en_d;
    end
  end

  // the release edge ends the low-high cycle
  assign drv_en_rise = drv_en_i && !drv_en_q;

  // ----------------------------------------------------------------
  // flag set and clear terms
  // ----------------------------------------------------------------
  logic [14:0] flag_set;
  logic [14:0] clr_write;
  logic [14:0] clr_cycle;
  logic [14:0] flag_clr;
  logic flag_write;

  assign flag_write = regs.we && gds_addr_hit(regs.addr, ADDR_GLOBAL_FAULT_FLAGS);

  always_comb begin
    flag_set = 15'h0000;
    flag_set[FLG_PREWARN_BIT] = temp_prewarn_i;
    flag_set[FLG_OVERTEMP_BIT] = overtemp_i;
    flag_set[FLG_PUMP_UV_BIT] = pump_undervoltage_i;
    for (int p = 0; p < PHASES; p++) begin
      flag_set[FLG_PHASE_BASE + p*FLG_PHASE_STRIDE + FLG_COUNTER_OFS] =
        short_counter_fire_i[p];
      flag_set[FLG_PHASE_BASE + p*FLG_PHASE_STRIDE + FLG_GROUND_OFS] =
        ground_short_i[p];
      flag_set[FLG_PHASE_BASE + p*FLG_PHASE_STRIDE + FLG_SUPPLY_OFS] =
        supply_short_i[p];
    end
  end

  always_comb begin
    clr_write = 15'h0000;
    if (flag_write) begin
      clr_write = regs.wdata[14:0] & FLG_USED_MASK;
      if (!drv_en_i) begin
        clr_write[FLG_RESET_BIT] = 1'b0;
      end
    end
  end

  always_comb begin
    clr_cycle = 15'h0000;
    if (drv_en_rise) begin
      clr_cycle = FLG_USED_MASK & ~FLG_KEEP_ON_CYCLE;
    end
  end

  assign flag_clr = clr_write | clr_cycle;

  // ----------------------------------------------------------------
  // fault flag register
  // ----------------------------------------------------------------
  logic [14:0] flags_q, flags_d;

  always_comb begin
    // a live cause outranks any clear in the same cycle
    flags_d = ((flags_q & ~flag_clr) | flag_set) & FLG_USED_MASK;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_q <= FLG_RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // per-phase short hold-off
  // ----------------------------------------------------------------
  logic [PHASES-1:0] hold_q, hold_d;
  logic [PHASES-1:0] short_flag;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      logic gates_off;
      assign short_flag[g] =
        flags_q[FLG_PHASE_BASE + g*FLG_PHASE_STRIDE + FLG_GROUND_OFS] |
        flags_q[FLG_PHASE_BASE + g*FLG_PHASE_STRIDE + FLG_SUPPLY_OFS];
      assign gates_off = !gate_in[2*g] && !gate_in[2*g+1];
      // hold stays until the flag is gone and both gate inputs are off
      always_comb begin
        hold_d[g] = hold_q[g];
        if (ground_short_i[g] || supply_short_i[g]) begin
          hold_d[g] = 1'b1;
        end else if (!short_flag[g] && gates_off) begin
          hold_d[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // driver, amplifier and probe outputs
  // ----------------------------------------------------------------
  logic drv_q, drv_d;
  logic [PHASES-1:0] phase_q, phase_d;
  logic status_q, status_d;
  logic [1:0] probe_q, probe_d;

  always_comb begin
    // prewarning plays no part here, it is information only
    drv_d = drv_en_i && !cfg[CFG_DISABLE_BIT] && !pump_undervoltage_i
            && !overtemp_i && !flags_q[FLG_OVERTEMP_BIT];
    phase_d = ~(short_flag | hold_q);
    status_d = |(flags_q & FLG_STATUS_PIN_MASK);
    probe_d = probe_func_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      drv_q <= 1'b0;
      phase_q <= '0;
      status_q <= 1'b0;
      probe_q <= 2'h0;
    end else begin
      drv_q <= drv_d;
      phase_q <= phase_d;
      status_q <= status_d;
      probe_q <= probe_d;
    end
  end

  assign driver_enable_o = drv_q;
  assign phase_enable_o = phase_q;
  assign status_o = status_q;
  assign sense_amp_enable_o = !cfg[CFG_AMP_OFF_BIT];
  assign amp_gain_o = cfg[CFG_AMP_LSB+1:CFG_AMP_LSB];
  assign single_line_mode_o = cfg[CFG_SINGLELINE_BIT];
  assign fault_direct_o = cfg[CFG_FAULTDIRECT_BIT];
  // enable pin level is unreliable while the probe drives it
  assign probe_route_o = cfg[CFG_TEST_MODE_BIT];
  assign probe_func_o = probe_q;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    regs.rdata = 32'h0000_0000;
    if (gds_addr_hit(regs.rd_addr, ADDR_GLOBAL_CONFIG_WORD)) begin
      regs.rdata[7:0] = cfg;
    end else if (gds_addr_hit(regs.rd_addr, ADDR_GLOBAL_FAULT_FLAGS)) begin
      regs.rdata[14:0] = flags_q;
    end else if (gds_addr_hit(regs.rd_addr, ADDR_INPUT_PIN_MIRROR)) begin
      regs.rdata[15:0] = mirror;
    end
  end

  // status byte leading every answer
  always_comb begin
    regs.status = 8'h00;
    regs.status[0] = flags_q[FLG_RESET_BIT];
    regs.status[1] = status_q;
    regs.status[2] = flags_q[FLG_PREWARN_BIT];
  end

endmodule : gds_status_regs

/* testbench/gds_host_model.sv */
/*
  host side serial master: 40-bit mode 3 frames, msb first.
  assumes start is raised at a falling clock edge and held until done.
*/
`timescale 1ns/10ps
module gds_host_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [39:0] tx_i,
  input wire logic sdo_i,
  output logic [39:0] rx_o,
  output logic done_o,
  output logic sck_o,
  output logic csn_o,
  output logic sdi_o
);
  initial begin
    sck_o = 1'b1;
    csn_o = 1'b1;
    sdi_o = 1'b0;
    done_o = 1'b0;
    rx_o = 40'h0;
  end
  // sck parks high between frames; sdi wanders so no stale bit is trusted
  always begin
    @(negedge clk_i);
    if (!start_i) sdi_o = ~sdi_o;
    else begin
      done_o = 1'b0;
      csn_o = 1'b0;
      repeat (3) @(negedge clk_i);
      for (int i = 39; i >= 0; i--) begin
        sck_o = 1'b0;
        sdi_o = tx_i[i];
        repeat (3) @(negedge clk_i);
        sck_o = 1'b1;
        rx_o[i] = sdo_i;
        repeat (3) @(negedge clk_i);
      end
      csn_o = 1'b1;
      repeat (5) @(negedge clk_i);
      done_o = 1'b1;
      wait (!start_i);
    end
  end
endmodule : gds_host_model

/* testbench/gds_status_regs_assertions.sv */
/*
  port checker for the status register bank.
  assumes it is bound onto gds_status_regs, one clock domain.
*/
`timescale 1ns/10ps
module gds_status_regs_assertions
  import gds_pkg::*;
#(
  parameter int PHASES = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic spi_csn_i,
  input wire logic spi_sdo_oe_o,
  input wire logic phase_a_low_input_i,
  input wire logic phase_a_high_input_i,
  input wire logic drv_en_i,
  input wire logic overtemp_i,
  input wire logic pump_undervoltage_i,
  input wire logic [PHASES-1:0] short_counter_fire_i,
  input wire logic [PHASES-1:0] ground_short_i,
  input wire logic [PHASES-1:0] supply_short_i,
  input wire logic driver_enable_o,
  input wire logic [PHASES-1:0] phase_enable_o,
  input wire logic status_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic cause;
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  assign cause = overtemp_i | pump_undervoltage_i | (|short_counter_fire_i) |
                 (|ground_short_i) | (|supply_short_i);
  // counts quiet cycles so a pending write strobe has landed
  always_comb begin
    idle_d = idle_q;
    if (!spi_csn_i) idle_d = 4'h0;
    else if (idle_q != 4'hf) idle_d = idle_q + 4'h1;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) idle_q <= 4'h0;
    else idle_q <= idle_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_open;
    !spi_csn_i ##1 !spi_csn_i;
  endsequence
  sequence s_closed;
    spi_csn_i ##1 spi_csn_i;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_UV_OFF: assert property (pump_undervoltage_i |=> !driver_enable_o)
    else $error("driver on during pump undervoltage");
  AST_OT_OFF: assert property (overtemp_i |=> !driver_enable_o)
    else $error("driver on during overtemperature");
  AST_STATUS_SET: assert property (cause |-> ##[1:2] status_o)
    else $error("status pin not raised by fault");
  AST_STATUS_CAUSE: assert property ($rose(status_o) |-> $past(cause) || $past(cause, 2))
    else $error("status pin rose without fault");
  AST_STATUS_HOLD: assert property (status_o && idle_q > 4'h8 && drv_en_i && $past(drv_en_i) &&
    $past(drv_en_i, 2) |=> status_o)
    else $error("status pin dropped without clear");
  AST_PHASE_SHORT: assert property (|(ground_short_i | supply_short_i) |=> ##1
    ((phase_enable_o & $past(ground_short_i | supply_short_i, 2)) == '0))
    else $error("phase left on after short");
  AST_PHASE_GATE: assert property ($rose(phase_enable_o[0]) && !$past(reset_i) &&
    !$past(reset_i, 2) |-> $past(!phase_a_low_input_i && !phase_a_high_input_i, 2))
    else $error("phase a re-enabled with gate input on");
  AST_OE_ON: assert property (s_open |-> spi_sdo_oe_o)
    else $error("sdo not enabled in frame");
  AST_OE_OFF: assert property (s_closed |-> !spi_sdo_oe_o)
    else $error("sdo enabled outside frame");
endmodule : gds_status_regs_assertions

/* testbench/testbench.sv */
/*
  self-checking bench for the status register bank over its serial port.
  assumes gds_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
module testbench
  import gds_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sck, csn, sdi, sdo, start, done;
  logic [39:0] tx, rx;
  logic [5:0] gates = 6'h00;
  logic drv_en = 1'b1;
  logic [14:0] stim = 15'h0000;
  logic drv_o, amp_o, line_o, fdir_o, route_o, stat_o;
  logic [2:0] ph_o;
  logic [1:0] gain_o, func_o;
  int err_count = 0;
  int checked = 0;
  always #25 clk_i = ~clk_i;
  gds_host_model i_gds_host_model (.clk_i(clk_i), .start_i(start), .tx_i(tx), .sdo_i(sdo),
    .rx_o(rx), .done_o(done), .sck_o(sck), .csn_o(csn), .sdi_o(sdi));
  gds_status_regs #(.PHASES(3)) i_gds_status_regs (.clk_i(clk_i), .reset_i(reset_i),
    .spi_sck_i(sck), .spi_csn_i(csn), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(),
    .phase_a_low_input_i(gates[0]), .phase_a_high_input_i(gates[1]),
    .phase_b_low_input_i(gates[2]), .phase_b_high_input_i(gates[3]),
    .phase_c_low_input_i(gates[4]), .phase_c_high_input_i(gates[5]), .drv_en_i(drv_en),
    .temp_prewarn_i(stim[1]), .overtemp_i(stim[2]), .pump_undervoltage_i(stim[3]),
    .short_counter_fire_i({stim[12], stim[8], stim[4]}),
    .ground_short_i({stim[13], stim[9], stim[5]}),
    .supply_short_i({stim[14], stim[10], stim[6]}), .probe_func_i(2'h2),
    .driver_enable_o(drv_o), .phase_enable_o(ph_o), .sense_amp_enable_o(amp_o),
    .amp_gain_o(gain_o), .single_line_mode_o(line_o), .fault_direct_o(fdir_o),
    .probe_route_o(route_o), .probe_func_o(func_o), .status_o(stat_o));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  task automatic xfer(input logic [39:0] f);
    int n;
    n = 0;
    tx = f;
    start = 1'b1;
    @(posedge clk_i);
    while (done !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) err_count++;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (done !== 1'b1) err_count++;
    @(negedge clk_i);
    start = 1'b0;
    // host must see start low before the next frame may begin
    @(negedge clk_i);
  endtask : xfer
  // answer carries the register picked by the previous frame, so read twice
  task automatic rc(input string n, input logic [6:0] a, input logic [31:0] e);
    xfer({1'b0, a, 32'h0});
    xfer({1'b0, a, 32'h0});
    chk(n, e, rx[31:0]);
  endtask : rc
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    xfer({1'b1, a, d});
  endtask : wr
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    start = 1'b0;
    tx = 40'h0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    idle(2);
    chk("amp_en", 32'h1, 32'(amp_o));
    chk("single_line", 32'h1, 32'(line_o));
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h1);
    chk("status_byte", 32'h1, 32'(rx[39:32]));
    rc("config", ADDR_GLOBAL_CONFIG_WORD, 32'h2);
    $display("test reset done");
    wr(ADDR_GLOBAL_CONFIG_WORD, 32'hffffffff);
    rc("config", ADDR_GLOBAL_CONFIG_WORD, 32'hf7);
    chk("amp_en", 32'h0, 32'(amp_o));
    chk("probe_route", 32'h1, 32'(route_o));
    chk("probe_func", 32'h2, 32'(func_o));
    chk("amp_gain", 32'h3, 32'(gain_o));
    chk("fault_direct", 32'h1, 32'(fdir_o));
    chk("drv_en", 32'h0, 32'(drv_o));
    wr(ADDR_GLOBAL_CONFIG_WORD, 32'h2);
    chk("amp_en", 32'h1, 32'(amp_o));
    $display("test config done");
    drv_en = 1'b0;
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h1);
    drv_en = 1'b1;
    idle(3);
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h1);
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h1);
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h0);
    $display("test reset flag done");
    for (int b = 1; b < 15; b++) begin
      if (FLG_USED_MASK[b]) begin
        stim = 15'h1 << b;
        idle(1);
        stim = 15'h0;
        idle(3);
        rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'(15'h1 << b));
        chk("status", 32'(FLG_STATUS_PIN_MASK[b]), 32'(stat_o));
        wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h0);
        rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'(15'h1 << b));
        wr(ADDR_GLOBAL_FAULT_FLAGS, 32'(15'h1 << b));
        rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h0);
      end
    end
    $display("test flags done");
    stim = 15'h0026;
    idle(1);
    stim = 15'h0;
    drv_en = 1'b0;
    idle(2);
    drv_en = 1'b1;
    idle(3);
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h2);
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h2);
    stim = 15'h0004;
    idle(2);
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h4);
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h4);
    chk("drv_en", 32'h0, 32'(drv_o));
    stim = 15'h0;
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h4);
    rc("flags", ADDR_GLOBAL_FAULT_FLAGS, 32'h0);
    $display("test clear rules done");
    gates = 6'h02;
    stim = 15'h0020;
    idle(1);
    stim = 15'h0;
    idle(3);
    chk("phase_en", 32'h0, 32'(ph_o[0]));
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h20);
    idle(3);
    chk("phase_en", 32'h0, 32'(ph_o[0]));
    gates = 6'h00;
    idle(3);
    chk("phase_en", 32'h1, 32'(ph_o[0]));
    $display("test short hold done");
    gates = 6'h2d;
    rc("mirror", ADDR_INPUT_PIN_MIRROR, 32'h6d);
    wr(ADDR_INPUT_PIN_MIRROR, 32'hffffffff);
    rc("mirror", ADDR_INPUT_PIN_MIRROR, 32'h6d);
    gates = 6'h00;
    rc("unmapped", 7'h02, 32'h0);
    $display("test mirror done");
    stim = 15'h0008;
    idle(2);
    chk("drv_en", 32'h0, 32'(drv_o));
    stim = 15'h0;
    wr(ADDR_GLOBAL_FAULT_FLAGS, 32'h8);
    idle(2);
    chk("drv_en", 32'h1, 32'(drv_o));
    $display("test undervoltage done");
    complete_run();
  end
  // a frame is some 250 cycles and the run needs well under 40000
  initial begin
    repeat (80000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
endmodule : testbench
bind gds_status_regs gds_status_regs_assertions #(.PHASES(PHASES)) i_gds_status_regs_assertions (
  .clk_i(clk_i), .reset_i(reset_i), .spi_csn_i(spi_csn_i), .spi_sdo_oe_o(spi_sdo_oe_o),
  .phase_a_low_input_i(phase_a_low_input_i), .phase_a_high_input_i(phase_a_high_input_i),
  .drv_en_i(drv_en_i), .overtemp_i(overtemp_i), .pump_undervoltage_i(pump_undervoltage_i),
  .short_counter_fire_i(short_counter_fire_i), .ground_short_i(ground_short_i),
  .supply_short_i(supply_short_i), .driver_enable_o(driver_enable_o),
  .phase_enable_o(phase_enable_o), .status_o(status_o));
